/* File: verilog/vrsdc_pkg.sv */
// vrsdc_pkg: constants shared by the sensor diagnosis control files
// assumes 25 MHz system clock and a plain one-cycle register port
package vrsdc_pkg;
  localparam int unsigned CLK_MHZ          = 25;
  localparam int unsigned CONV_TIME_US     = 8;
  localparam int unsigned CONV_CYC         = CONV_TIME_US * CLK_MHZ;
  localparam logic [3:0]  OFF_CFG_A        = 4'h0;
  localparam logic [3:0]  OFF_CFG_B        = 4'h1;
  localparam logic [3:0]  OFF_CFG_C        = 4'h2;
  localparam logic [3:0]  OFF_CMD          = 4'h3;
  localparam logic [3:0]  OFF_DIAG_A       = 4'h4;
  localparam logic [3:0]  OFF_DIAG_B       = 4'h5;
  localparam logic [3:0]  OFF_IRQ_STAT     = 4'h6;
  localparam logic [3:0]  OFF_IRQ_EN       = 4'h7;
  localparam logic [3:0]  OFF_IRQ_CLR      = 4'h8;
  localparam int unsigned A_PV_LSB         = 0;
  localparam int unsigned A_PT_BIT         = 2;
  localparam int unsigned A_FLT_LSB        = 3;
  localparam int unsigned B_DM_LSB         = 0;
  localparam int unsigned B_DG_LSB         = 2;
  localparam int unsigned B_ISC_LSB        = 4;
  localparam int unsigned C_IOL_LSB        = 0;
  localparam int unsigned C_IADC_LSB       = 2;
  localparam int unsigned CMD_START_BIT    = 0;
  localparam int unsigned DA_SG_BIT        = 0;
  localparam int unsigned DA_SB_BIT        = 1;
  localparam int unsigned DA_OL_BIT        = 2;
  localparam int unsigned DA_DVSC_BIT      = 3;
  localparam int unsigned DA_DVOL_BIT      = 4;
  localparam int unsigned DB_DVADC_BIT     = 7;
  localparam logic [1:0]  PV_RESET         = 2'h0;
  localparam logic        PT_RESET         = 1'b0;
  localparam logic [6:0]  ADC_ZERO_CODE    = 7'h25;
  localparam int unsigned ADC_MV_PER_CODE  = 49;
  localparam logic [6:0]  ADC_LIN_MIN      = 7'h06;
  localparam logic [6:0]  ADC_LIN_MAX      = 7'h46;
  typedef enum logic [1:0] {DET_AUTO, DET_MANUAL, DET_SEMI, DET_HALL} vrsdc_det_t;
  typedef enum logic [1:0] {DG_OFF, DG_SHORT, DG_OPEN, DG_ADC} vrsdc_dg_t;
endpackage

/* File: verilog/vrsdc_sync_cnt.sv */
// vrsdc_sync_cnt: conversion timer, pulses done after a set cycle count
// assumes start is a one-cycle pulse; a new start restarts the count
`timescale 1ns/10ps
`default_nettype none
module vrsdc_sync_cnt #(
  parameter int unsigned CYCLES = 200
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [15:0] cnt_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 16'h0000;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= 16'(CYCLES - 1);
        busy    <= 1'b1;
      end else if (busy) begin
        if (cnt_reg == 16'h0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/vrsdc_adc_cap.sv */
// vrsdc_adc_cap: registers the converter code and pin comparator levels
// assumes analog front end inputs are synchronous and stable at capture
`timescale 1ns/10ps
`default_nettype none
module vrsdc_adc_cap (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       capture,
  input  wire logic [6:0] adc_code,
  input  wire logic [2:0] cmp_in,
  output logic      [6:0] code_q,
  output logic      [2:0] cmp_q
);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      code_q <= 7'h00;
      cmp_q  <= 3'h0;
    end else if (capture) begin
      code_q <= adc_code;
      cmp_q  <= cmp_in;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/vrsdc_top.sv */
// vrsdc_top: diagnosis control for a variable-reluctance sensor pin pair
// assumes host on a one-cycle register port, analog levels synchronous
// Notes on behaviour
// - three diagnosis modes: short, open load, adc; chosen by mode field
// - diagnosis runs only when start command written after mode chosen
// - active mode enables pull-up on pos pin, pull-down on neg pin
// - finished diagnosis sets its own data-valid flag
// - short to ground, short to battery, open load flags in status a
// - adc result code in status b, readable by host
// - valid flag clears on restart of its mode or read of its register
// - hall mode disables diagnosis; mode, currents and start ignored
// - adc code about 49 mV per step, zero offset 37, linear 6..70
// - peak amplitude four settings, 50 mV after reset
// - peak time two settings, 10 us after reset
// - peak settings held in configuration register a
// - peak field writes ignored in auto, semi-auto and hall modes
// - detection mode field in configuration register b
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module vrsdc_top #(
  parameter int unsigned CONV_CYCLES = vrsdc_pkg::CONV_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [6:0] adc_code_in,
  input  wire logic       cmp_short_gnd,
  input  wire logic       cmp_short_bat,
  input  wire logic       cmp_open_load,
  output logic            pullup_pos_en,
  output logic            pulldown_neg_en,
  output logic      [1:0] pull_current_sel,
  output logic            adc_conv_active,
  output logic      [1:0] peak_amplitude_sel,
  output logic            peak_time_sel,
  output logic      [1:0] detect_mode_sel,
  output logic      [1:0] out_filter_sel,
  output logic            irq
);
  // configuration registers
  logic [1:0] peak_amp_reg;
  logic       peak_time_reg;
  logic [1:0] filt_reg;
  logic [1:0] det_mode_reg;
  logic [1:0] diag_mode_sel_reg;
  logic [1:0] short_test_current_sel_reg;
  logic [1:0] openload_test_current_sel_reg;
  logic [1:0] adc_test_current_sel_reg;
  // status
  logic       short_to_ground_flag_reg;
  logic       short_to_battery_flag_reg;
  logic       open_load_flag_reg;
  logic       short_result_valid_reg;
  logic       openload_result_valid_reg;
  logic       adc_result_valid_reg;
  logic [6:0] adc_result_value_reg;
  logic [1:0] run_mode_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_en_reg;
  // decode
  wire        wr_cfg_a  = reg_wr && (reg_addr == vrsdc_pkg::OFF_CFG_A);
  wire        wr_cfg_b  = reg_wr && (reg_addr == vrsdc_pkg::OFF_CFG_B);
  wire        wr_cfg_c  = reg_wr && (reg_addr == vrsdc_pkg::OFF_CFG_C);
  wire        wr_cmd    = reg_wr && (reg_addr == vrsdc_pkg::OFF_CMD);
  wire        wr_irq_en = reg_wr && (reg_addr == vrsdc_pkg::OFF_IRQ_EN);
  wire        wr_irq_cl = reg_wr && (reg_addr == vrsdc_pkg::OFF_IRQ_CLR);
  wire        rd_diag_a = reg_rd && (reg_addr == vrsdc_pkg::OFF_DIAG_A);
  wire        rd_diag_b = reg_rd && (reg_addr == vrsdc_pkg::OFF_DIAG_B);
  wire        hall_mode = (det_mode_reg == 2'(vrsdc_pkg::DET_HALL));
  wire        manual_mode = (det_mode_reg == 2'(vrsdc_pkg::DET_MANUAL));
  wire [1:0]  diag_eff  = hall_mode ? 2'(vrsdc_pkg::DG_OFF) : diag_mode_sel_reg;
  wire        diag_on   = (diag_eff != 2'(vrsdc_pkg::DG_OFF));
  // start only with a mode chosen, never in hall mode
  wire        start_req = wr_cmd && reg_wdata[vrsdc_pkg::CMD_START_BIT];
  wire        start_ok  = start_req && diag_on && !hall_mode;
  wire        st_short  = start_ok && (diag_eff == 2'(vrsdc_pkg::DG_SHORT));
  wire        st_open   = start_ok && (diag_eff == 2'(vrsdc_pkg::DG_OPEN));
  wire        st_adc    = start_ok && (diag_eff == 2'(vrsdc_pkg::DG_ADC));
  // per-mode current selection
  wire [1:0]  cur_sel   = (diag_eff == 2'(vrsdc_pkg::DG_SHORT)) ? short_test_current_sel_reg :
                          (diag_eff == 2'(vrsdc_pkg::DG_OPEN))  ? openload_test_current_sel_reg :
                          (diag_eff == 2'(vrsdc_pkg::DG_ADC))   ? adc_test_current_sel_reg :
                          2'h0;
  wire        conv_busy;
  wire        conv_done;
  wire [6:0]  cap_code;
  wire [2:0]  cap_cmp;
  logic       cap_pulse_reg;
  wire        done_short = cap_pulse_reg && (run_mode_reg == 2'(vrsdc_pkg::DG_SHORT));
  wire        done_open  = cap_pulse_reg && (run_mode_reg == 2'(vrsdc_pkg::DG_OPEN));
  wire        done_adc   = cap_pulse_reg && (run_mode_reg == 2'(vrsdc_pkg::DG_ADC));
  wire [2:0]  irq_events = {done_adc, done_open, done_short};
  wire [7:0]  rd_cfg_a = {3'h0, filt_reg, peak_time_reg, peak_amp_reg};
  wire [7:0]  rd_cfg_b = {2'h0, short_test_current_sel_reg, diag_mode_sel_reg, det_mode_reg};
  wire [7:0]  rd_cfg_c = {4'h0, adc_test_current_sel_reg, openload_test_current_sel_reg};
  wire [7:0]  rd_dg_a  = {3'h0, openload_result_valid_reg, short_result_valid_reg,
                          open_load_flag_reg, short_to_battery_flag_reg,
                          short_to_ground_flag_reg};
  wire [7:0]  rd_dg_b  = {adc_result_valid_reg, adc_result_value_reg};
  wire [7:0]  rd_mux   = (reg_addr == vrsdc_pkg::OFF_CFG_A)    ? rd_cfg_a :
                         (reg_addr == vrsdc_pkg::OFF_CFG_B)    ? rd_cfg_b :
                         (reg_addr == vrsdc_pkg::OFF_CFG_C)    ? rd_cfg_c :
                         (reg_addr == vrsdc_pkg::OFF_DIAG_A)   ? rd_dg_a :
                         (reg_addr == vrsdc_pkg::OFF_DIAG_B)   ? rd_dg_b :
                         (reg_addr == vrsdc_pkg::OFF_IRQ_STAT) ? {5'h00, irq_stat_reg} :
                         (reg_addr == vrsdc_pkg::OFF_IRQ_EN)   ? {5'h00, irq_en_reg} :
                         8'h00;

  // conversion timer, restarted by each accepted start
  vrsdc_sync_cnt #(
    .CYCLES (CONV_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (start_ok),
    .busy    (conv_busy),
    .done    (conv_done)
  );

  // result capture at end of measurement
  vrsdc_adc_cap u_cap (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .capture  (conv_done),
    .adc_code (adc_code_in),
    .cmp_in   ({cmp_open_load, cmp_short_bat, cmp_short_gnd}),
    .code_q   (cap_code),
    .cmp_q    (cap_cmp)
  );

  // configuration a: peak settings only writable in manual mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      peak_amp_reg  <= vrsdc_pkg::PV_RESET;
      peak_time_reg <= vrsdc_pkg::PT_RESET;
      filt_reg      <= 2'h0;
    end else if (wr_cfg_a) begin
      filt_reg <= reg_wdata[vrsdc_pkg::A_FLT_LSB +: 2];
      if (manual_mode) begin
        peak_amp_reg  <= reg_wdata[vrsdc_pkg::A_PV_LSB +: 2];
        peak_time_reg <= reg_wdata[vrsdc_pkg::A_PT_BIT];
      end
    end
  end

  // configuration b and c: detection mode, diagnosis mode and currents
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      det_mode_reg                  <= 2'(vrsdc_pkg::DET_AUTO);
      diag_mode_sel_reg             <= 2'(vrsdc_pkg::DG_OFF);
      short_test_current_sel_reg    <= 2'h0;
      openload_test_current_sel_reg <= 2'h0;
      adc_test_current_sel_reg      <= 2'h0;
    end else begin
      if (wr_cfg_b) begin
        det_mode_reg               <= reg_wdata[vrsdc_pkg::B_DM_LSB +: 2];
        diag_mode_sel_reg          <= reg_wdata[vrsdc_pkg::B_DG_LSB +: 2];
        short_test_current_sel_reg <= reg_wdata[vrsdc_pkg::B_ISC_LSB +: 2];
      end
      if (wr_cfg_c) begin
        openload_test_current_sel_reg <= reg_wdata[vrsdc_pkg::C_IOL_LSB +: 2];
        adc_test_current_sel_reg      <= reg_wdata[vrsdc_pkg::C_IADC_LSB +: 2];
      end
    end
  end

  // running mode latched at start, capture pulse follows timer done
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_mode_reg  <= 2'(vrsdc_pkg::DG_OFF);
      cap_pulse_reg <= 1'b0;
    end else begin
      cap_pulse_reg <= conv_done;
      if (start_ok) begin
        run_mode_reg <= diag_eff;
      end
    end
  end

  // results and valid flags; completion wins over read clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      short_to_ground_flag_reg  <= 1'b0;
      short_to_battery_flag_reg <= 1'b0;
      open_load_flag_reg        <= 1'b0;
      short_result_valid_reg    <= 1'b0;
      openload_result_valid_reg <= 1'b0;
      adc_result_valid_reg      <= 1'b0;
      adc_result_value_reg      <= 7'h00;
    end else begin
      if (done_short) begin
        short_to_ground_flag_reg  <= cap_cmp[0];
        short_to_battery_flag_reg <= cap_cmp[1];
        short_result_valid_reg    <= 1'b1;
      end else if (st_short || rd_diag_a) begin
        short_result_valid_reg <= 1'b0;
      end
      if (done_open) begin
        open_load_flag_reg        <= cap_cmp[2];
        openload_result_valid_reg <= 1'b1;
      end else if (st_open || rd_diag_a) begin
        openload_result_valid_reg <= 1'b0;
      end
      if (done_adc) begin
        adc_result_value_reg <= cap_code;
        adc_result_valid_reg <= 1'b1;
      end else if (st_adc || rd_diag_b) begin
        adc_result_valid_reg <= 1'b0;
      end
    end
  end

  // interrupt status: set wins over clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_reg <= 3'h0;
      irq_en_reg   <= 3'h0;
    end else begin
      irq_stat_reg <= irq_events | (irq_stat_reg & ~({3{wr_irq_cl}} & reg_wdata[2:0]));
      if (wr_irq_en) begin
        irq_en_reg <= reg_wdata[2:0];
      end
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata          <= 8'h00;
      pullup_pos_en      <= 1'b0;
      pulldown_neg_en    <= 1'b0;
      pull_current_sel   <= 2'h0;
      adc_conv_active    <= 1'b0;
      peak_amplitude_sel <= vrsdc_pkg::PV_RESET;
      peak_time_sel      <= vrsdc_pkg::PT_RESET;
      detect_mode_sel    <= 2'(vrsdc_pkg::DET_AUTO);
      out_filter_sel     <= 2'h0;
      irq                <= 1'b0;
    end else begin
      reg_rdata          <= reg_rd ? rd_mux : 8'h00;
      pullup_pos_en      <= diag_on;
      pulldown_neg_en    <= diag_on;
      pull_current_sel   <= cur_sel;
      adc_conv_active    <= conv_busy;
      peak_amplitude_sel <= peak_amp_reg;
      peak_time_sel      <= peak_time_reg;
      detect_mode_sel    <= det_mode_reg;
      out_filter_sel     <= filt_reg;
      irq                <= |(irq_stat_reg & irq_en_reg);
    end
  end
endmodule
`default_nettype wire

/* File: tb/vrsdc_top_properties.sv */
// vrsdc_top_properties: port-level checks for the sensor diagnosis control
// bound into vrsdc_top; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module vrsdc_top_properties #(
  parameter int unsigned CONV_CYCLES = 5
) (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pullup_pos_en,
  input wire logic       pulldown_neg_en,
  input wire logic [1:0] pull_current_sel,
  input wire logic       adc_conv_active,
  input wire logic [1:0] peak_amplitude_sel,
  input wire logic       peak_time_sel,
  input wire logic [1:0] detect_mode_sel,
  input wire logic       irq
);
  logic [15:0] run_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // length of the current conversion run
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) run_cnt <= 16'h0000;
    else run_cnt <= adc_conv_active ? run_cnt + 16'h0001 : 16'h0000;
  end
  property p_pull_pair; pullup_pos_en == pulldown_neg_en; endproperty
  a_pull_pair: assert property (p_pull_pair) else $error("pull sources differ");
  property p_cur_off; pull_current_sel != 2'h0 |-> pullup_pos_en; endproperty
  a_cur_off: assert property (p_cur_off) else $error("current without mode");
  property p_hall_off;
    detect_mode_sel == 2'h3 && $past(detect_mode_sel) == 2'h3 |-> !pullup_pos_en;
  endproperty
  a_hall_off: assert property (p_hall_off) else $error("pull on in hall mode");
  property p_start_gate; $rose(adc_conv_active) |-> $past(pullup_pos_en); endproperty
  a_start_gate: assert property (p_start_gate) else $error("start without mode");
  property p_conv_len; run_cnt <= CONV_CYCLES + 1; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too long");
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_irq_mask; reg_wr && reg_addr == 4'h7 && reg_wdata == 8'h00 |-> ##2 !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
  property p_reset_val;
    $rose(rstn) |-> peak_amplitude_sel == 2'h0 && !peak_time_sel && detect_mode_sel == 2'h0;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset setting");
  property p_peak_lock;
    reg_wr && reg_addr == 4'h0 && detect_mode_sel != 2'h1
      |=> ($stable(peak_amplitude_sel) && $stable(peak_time_sel)) [*3];
  endproperty
  a_peak_lock: assert property (p_peak_lock) else $error("peak field changed");
  property p_mode_copy;
    reg_wr && reg_addr == 4'h1 |-> ##3 detect_mode_sel == $past(reg_wdata[1:0], 3);
  endproperty
  a_mode_copy: assert property (p_mode_copy) else $error("detect mode wrong");
  c_conv_end: cover property ($fell(adc_conv_active));
  c_irq: cover property (irq);
  c_hall_start: cover property (detect_mode_sel == 2'h3 && reg_wr && reg_addr == 4'h3);
endmodule
bind vrsdc_top vrsdc_top_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pullup_pos_en(pullup_pos_en),
  .pulldown_neg_en(pulldown_neg_en), .pull_current_sel(pull_current_sel),
  .adc_conv_active(adc_conv_active), .peak_amplitude_sel(peak_amplitude_sel),
  .peak_time_sel(peak_time_sel), .detect_mode_sel(detect_mode_sel), .irq(irq));
`default_nettype wire

/* File: tb/vrsdc_sensor_model.sv */
// vrsdc_sensor_model: sensor pin pair seen through the analog front end
// levels mean something only while the pull sources are on
`timescale 1ns/10ps
`default_nettype none
module vrsdc_sensor_model (
  input  wire logic               sys_clk,
  input  wire logic               pull_on,
  input  wire logic        [2:0]  fault,
  input  wire logic signed [11:0] diff_mv,
  output logic             [6:0]  adc_code,
  output logic             [2:0]  cmp
);
  logic               junk = 1'b0;
  logic signed [11:0] steps;
  always @(posedge sys_clk) junk <= ~junk;
  // 49 mV a step around code 37
  assign steps = diff_mv / 12'sd49;
  // unbiased pins float: changing pattern
  assign adc_code = pull_on ? 7'(steps + 12'sd37) : {7{junk}};
  assign cmp = pull_on ? fault : {3{junk}};
endmodule
`default_nettype wire

/* File: tb/vrsdc_top_bench.sv */
// vrsdc_top_bench: self-checking bench for the diagnosis control block
// drives the register port, sensor model stands on the pin side
`timescale 1ns/10ps
`default_nettype none
module vrsdc_top_bench;
  localparam int unsigned CONV = 5;
  logic               sys_clk = 1'b0;
  logic               rstn = 1'b0;
  logic        [3:0]  reg_addr = 4'h0;
  logic        [7:0]  reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic        [2:0]  fault = 3'h0;
  logic signed [11:0] mv = 12'sh000;
  logic        [7:0]  reg_rdata, d;
  logic        [6:0]  adc_code;
  logic        [2:0]  cmp;
  logic               pu, pd, act, ps, irq;
  logic        [1:0]  cur, pa, dm, flt;
  int                 fail_count = 0;
  int                 checked = 0;
  always #20 sys_clk = ~sys_clk;
  vrsdc_top #(.CONV_CYCLES(CONV)) uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_code_in(adc_code), .cmp_short_gnd(cmp[0]), .cmp_short_bat(cmp[1]),
    .cmp_open_load(cmp[2]), .pullup_pos_en(pu), .pulldown_neg_en(pd),
    .pull_current_sel(cur), .adc_conv_active(act), .peak_amplitude_sel(pa),
    .peak_time_sel(ps), .detect_mode_sel(dm), .out_filter_sel(flt), .irq(irq));
  vrsdc_sensor_model pm (.sys_clk(sys_clk), .pull_on(pu), .fault(fault), .diff_mv(mv),
    .adc_code(adc_code), .cmp(cmp));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  // select mode, let pins settle, start, wait for the result
  task automatic diag(input logic [7:0] cfgb, input logic [2:0] f, input logic [11:0] v,
                      input logic run);
    fault <= f;
    mv <= v;
    wr(4'h1, cfgb);
    cyc(4);
    wr(4'h3, 8'h01);
    cyc(2);
    chk({7'h00, act}, {7'h00, run});
    cyc(CONV + 6);
  endtask
  task automatic t_reset;
    rd(4'h4);
    chk(d, 8'h00);
    rd(4'h5);
    chk(d, 8'h00);
    rd(4'hF);
    chk(d, 8'h00);
    chk({5'h00, ps, pa}, 8'h00);
  endtask
  task automatic t_diag;
    wr(4'h2, 8'h09);
    wr(4'h7, 8'h07);
    diag(8'h35, 3'b010, 12'h000, 1'b1);
    chk({5'h00, pu & pd, cur}, 8'h07);
    chk({7'h00, irq}, 8'h01);
    rd(4'h4);
    chk(d & 8'h0B, 8'h0A);
    rd(4'h4);
    chk(d & 8'h08, 8'h00);
    diag(8'h09, 3'b100, 12'h000, 1'b1);
    chk({6'h00, cur}, 8'h01);
    wr(4'h3, 8'h01);
    rd(4'h4);
    chk(d & 8'h10, 8'h00);
    cyc(CONV + 8);
    rd(4'h4);
    chk(d & 8'h14, 8'h14);
    diag(8'h0D, 3'b000, 12'd490, 1'b1);
    chk({6'h00, cur}, 8'h02);
    rd(4'h5);
    chk(d, 8'hAF);
    diag(8'h0D, 3'b000, -12'sd980, 1'b1);
    rd(4'h5);
    chk(d, 8'h91);
    rd(4'h5);
    chk(d, 8'h11);
  endtask
  task automatic t_irq;
    wr(4'h7, 8'h00);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    rd(4'h6);
    chk(d, 8'h07);
    wr(4'h7, 8'h07);
    cyc(3);
    chk({7'h00, irq}, 8'h01);
    wr(4'h8, 8'h07);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    rd(4'h6);
    chk(d, 8'h00);
  endtask
  task automatic t_gate;
    diag(8'h01, 3'b111, 12'd490, 1'b0);
    rd(4'h4);
    chk(d, 8'h06);
    rd(4'h5);
    chk(d, 8'h11);
    diag(8'h3F, 3'b111, 12'd490, 1'b0);
    chk({4'h0, act, pu, cur}, 8'h00);
    rd(4'h5);
    chk(d, 8'h11);
  endtask
  task automatic t_peak;
    wr(4'h1, 8'h01);
    cyc(4);
    for (int v = 0; v < 8; v++) begin
      wr(4'h0, 8'(v));
      cyc(3);
      chk({5'h00, ps, pa}, 8'(v));
    end
    for (int m = 0; m < 4; m++) begin
      wr(4'h1, 8'(m));
      cyc(4);
      chk({6'h00, dm}, 8'(m));
      wr(4'h0, 8'(m + 4));
      cyc(3);
      chk({5'h00, ps, pa}, m == 0 ? 8'h07 : 8'h05);
    end
    wr(4'h0, 8'h1A);
    cyc(3);
    chk({3'h0, flt, ps, pa}, 8'h1D);
  endtask
  task automatic summarize;
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_diag();
    t_irq();
    t_gate();
    t_peak();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
